// ---- common/rspc_consts.svh ----
// Constants of the ROM shared port and strap capture block
`ifndef RSPC_CONSTS_SVH
`define RSPC_CONSTS_SVH

// ****************************************************************
// Strap pin positions
// ****************************************************************
`define RSPC_STRAP_ARB_POS      7
`define RSPC_STRAP_CENTRAL_POS  6
`define RSPC_STRAP_SCLK_POS     5
`define RSPC_STRAP_ASYNC_POS    4
`define RSPC_STRAP_LOCKOUT_POS  3
`define RSPC_STRAP_LOW_POS      3

// ****************************************************************
// Serial line positions on the shared pins
// ****************************************************************
`define RSPC_SER_WRITE_POS      2
`define RSPC_SER_READ_POS       1
`define RSPC_SER_CLOCK_POS      0

// ****************************************************************
// Sequencing figures
// ****************************************************************
`define RSPC_ADDR_BYTES         2'd3
`define RSPC_DATA_CYCLES        4
`define RSPC_SER_BITS           16
`define RSPC_PRELOAD_PATTERN    2'b10
`define RSPC_PINS_RESET         8'h00

`endif

// ---- common/rspc_pkg.sv ----
// Types of the ROM shared port and strap capture block
package rspc_pkg;

    typedef struct packed {
        logic arb_enable;
        logic central_tristate;
        logic sec_clk_enable;
        logic async_mode;
        logic lockout_init;
    } rspc_straps_t;

    typedef enum logic [2:0] {
        RSPC_IDLE,
        RSPC_PRELOAD,
        RSPC_PAR_ADDR,
        RSPC_PAR_DATA,
        RSPC_SER_SHIFT
    } rspc_state_t;

endpackage

// ---- rtl/rspc_strap_latch.sv ----
// Strap capture during primary reset and primary lockout bit
`timescale 1ns/1ps
`include "rspc_consts.svh"

module rspc_strap_latch (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           pins,
    input  wire logic                 lockout_clear,
    output rspc_pkg::rspc_straps_t    straps,
    output logic                      lockout
);
    import rspc_pkg::*;

    rspc_straps_t pin_straps;

    assign pin_straps.arb_enable       = pins[`RSPC_STRAP_ARB_POS];
    assign pin_straps.central_tristate = pins[`RSPC_STRAP_CENTRAL_POS];
    assign pin_straps.sec_clk_enable   = pins[`RSPC_STRAP_SCLK_POS];
    assign pin_straps.async_mode       = pins[`RSPC_STRAP_ASYNC_POS];
    assign pin_straps.lockout_init     = pins[`RSPC_STRAP_LOCKOUT_POS];

    // Track pins through reset, hold last value after release
    always_ff @(posedge clk) begin
        if (rst) begin
            straps  <= pin_straps;
            lockout <= pin_straps.lockout_init;
        end else if (lockout_clear) begin
            lockout <= 1'b0;
        end
    end

endmodule // rspc_strap_latch

// ---- rtl/rspc_top.sv ----
// ROM shared pin sequencer with reset strap capture
//
// Overview of operation
// - Parallel access drives address 23..16, 15..8, 7..0, then the data byte on writes.
// - Serial ROM uses pin 2 write data, pin 1 read data, pin 0 clock.
// - During primary reset, pins 7..3 are pulled externally and taken as options.
// - Pin 7 low disables arbiter; grant 0 becomes request, request 0 grant.
// - Pin 6 low parks wide request and bus low during secondary reset.
// - Pin 5 low holds secondary clock low, high passes primary clock.
// - Pin 4 high selects asynchronous interfaces, low synchronous.
// - Pin 3 sets lockout after reset; lockout retries config until cleared.
// - Preload runs only on pattern 10b; a first bit of 0 stops it after that bit.
// - Pin 2 is not strapped; it is sampled during the first serial read.
// - Serial ROM select is driven high to enable a read or write.
// - Latch enable low from first address byte until last address byte.
// - Latch clock output is the primary clock divided by two.
`timescale 1ns/1ps
`include "rspc_consts.svh"

module rspc_top #(
    parameter int DATA_CYCLES = `RSPC_DATA_CYCLES,
    parameter int SER_BITS    = `RSPC_SER_BITS
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  SYS_RST,
    input  wire logic [7:0]            ROM_AD_IN,
    output logic      [7:0]            ROM_AD_OUT,
    output logic      [7:0]            ROM_AD_OE,
    output logic                       ROM_LATCH_ENABLE_N,
    output logic                       ROM_LATCH_CLOCK,
    output logic                       SERIAL_ROM_SELECT,
    input  wire logic                  PAR_REQ,
    input  wire logic                  PAR_WRITE,
    input  wire logic [23:0]           PAR_ADDR,
    input  wire logic [7:0]            PAR_WDATA,
    output logic      [7:0]            PAR_RDATA,
    input  wire logic                  SER_REQ,
    input  wire logic [SER_BITS-1:0]   SER_TX,
    output logic      [SER_BITS-1:0]   SER_RX,
    output logic                       BUSY,
    output logic                       DONE,
    output logic                       PRELOAD_ENABLE,
    output logic                       PRELOAD_DONE,
    output logic                       SER_BIAS_LEVEL,
    input  wire logic                  SEC_RESET,
    input  wire logic                  LOCKOUT_CLEAR,
    output logic                       ARB_ENABLE,
    output logic                       OWN_REQ_ON_GNT0,
    output logic                       SEC_WIDE_REQUEST_N,
    output logic                       SEC_WIDE_REQUEST_OE,
    output logic                       SEC_BUS_PARK_LOW,
    output logic                       SEC_CLK_ENABLE,
    output logic                       ASYNC_MODE,
    output logic                       PRIMARY_LOCKOUT,
    output logic                       CONFIG_RETRY
);
    import rspc_pkg::*;

    localparam int CNT_W = (DATA_CYCLES > SER_BITS) ? $clog2(DATA_CYCLES + 1)
                                                    : $clog2(SER_BITS + 1);

    // Refuse counts the sequencer cannot serve
    if (DATA_CYCLES < 1 || SER_BITS < 2) begin : g_param_check
        $error("rspc_top: DATA_CYCLES must be >= 1 and SER_BITS >= 2");
    end

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    rspc_straps_t straps;
    logic         lockout;

    rspc_strap_latch i_rspc_strap_latch (
        .clk           (SYS_CLK),
        .rst           (SYS_RST),
        .pins          (ROM_AD_IN),
        .lockout_clear (LOCKOUT_CLEAR),
        .straps        (straps),
        .lockout       (lockout)
    );

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    rspc_state_t        state;
    logic               phase;
    logic [1:0]         byte_idx;
    logic [CNT_W-1:0]   cnt;
    logic               write_op;
    logic [23:0]        addr;
    logic [7:0]         wdata;
    logic [SER_BITS-1:0] shreg;
    logic               pre_first;

    // Phase 0 edges close each two-cycle latch clock period
    wire byte_end   = ~phase;
    wire last_addr  = byte_end && (byte_idx == `RSPC_ADDR_BYTES - 2'd1);
    wire data_end   = (cnt == CNT_W'(DATA_CYCLES - 1));
    wire ser_end    = byte_end && (cnt == CNT_W'(SER_BITS - 1));
    wire read_bit   = ROM_AD_IN[`RSPC_SER_READ_POS];
    wire [1:0] pre_pattern = `RSPC_PRELOAD_PATTERN;
    wire pre_ok_1st = (read_bit == pre_pattern[1]);
    wire pre_ok_2nd = (read_bit == pre_pattern[0]);

    wire [7:0] addr_byte = (byte_idx == 2'd0) ? addr[23:16] :
                           (byte_idx == 2'd1) ? addr[15:8]  :
                                                addr[7:0];

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state              <= RSPC_PRELOAD;
            phase              <= 1'b0;
            byte_idx           <= 2'd0;
            cnt                <= '0;
            write_op           <= 1'b0;
            addr               <= 24'h00_0000;
            wdata              <= 8'h00;
            shreg              <= '0;
            pre_first          <= 1'b1;
            ROM_AD_OUT         <= `RSPC_PINS_RESET;
            ROM_AD_OE          <= `RSPC_PINS_RESET;
            ROM_LATCH_ENABLE_N <= 1'b1;
            ROM_LATCH_CLOCK    <= 1'b0;
            SERIAL_ROM_SELECT  <= 1'b0;
            PAR_RDATA          <= 8'h00;
            SER_RX             <= '0;
            BUSY               <= 1'b1;
            DONE               <= 1'b0;
            PRELOAD_ENABLE     <= 1'b0;
            PRELOAD_DONE       <= 1'b0;
            SER_BIAS_LEVEL     <= 1'b0;
        end else begin
            phase           <= ~phase;
            ROM_LATCH_CLOCK <= ~ROM_LATCH_CLOCK;
            DONE            <= 1'b0;
            case (state)
                RSPC_IDLE: begin
                    ROM_AD_OE <= 8'h00;
                    // One request at a time, parallel first
                    if (PAR_REQ && !phase) begin
                        state              <= RSPC_PAR_ADDR;
                        write_op           <= PAR_WRITE;
                        addr               <= PAR_ADDR;
                        wdata              <= PAR_WDATA;
                        byte_idx           <= 2'd0;
                        BUSY               <= 1'b1;
                        ROM_AD_OE          <= 8'hFF;
                        ROM_AD_OUT         <= PAR_ADDR[23:16];
                        ROM_LATCH_ENABLE_N <= 1'b0;
                    end else if (SER_REQ && !phase) begin
                        state             <= RSPC_SER_SHIFT;
                        shreg             <= SER_TX;
                        cnt               <= '0;
                        BUSY              <= 1'b1;
                        SERIAL_ROM_SELECT <= 1'b1;
                        ROM_AD_OE         <= 8'h05;
                        ROM_AD_OUT        <= {5'h00, SER_TX[SER_BITS-1], 2'b00};
                    end else begin
                        BUSY <= 1'b0;
                    end
                end
                RSPC_PRELOAD: begin
                    // First read: write line left to its pull-up
                    SERIAL_ROM_SELECT <= 1'b1;
                    ROM_AD_OE         <= 8'h01;
                    ROM_AD_OUT        <= {7'h00, phase};
                    // No sample before the select has been raised
                    if (byte_end && SERIAL_ROM_SELECT) begin
                        pre_first <= 1'b0;
                        if (pre_first) begin
                            SER_BIAS_LEVEL <= ROM_AD_IN[`RSPC_SER_WRITE_POS];
                        end
                        if (!pre_first || !pre_ok_1st) begin
                            // Stop after the first bit unless it matched
                            state             <= RSPC_IDLE;
                            PRELOAD_ENABLE    <= !pre_first && pre_ok_2nd;
                            PRELOAD_DONE      <= 1'b1;
                            SERIAL_ROM_SELECT <= 1'b0;
                            ROM_AD_OE         <= 8'h00;
                            ROM_AD_OUT        <= 8'h00;
                        end
                    end
                end
                RSPC_PAR_ADDR: begin
                    if (byte_end) begin
                        byte_idx <= byte_idx + 2'd1;
                        if (last_addr) begin
                            // Address held in latches, move to data byte
                            state              <= RSPC_PAR_DATA;
                            cnt                <= '0;
                            ROM_LATCH_ENABLE_N <= 1'b1;
                            ROM_AD_OUT         <= write_op ? wdata : 8'h00;
                            ROM_AD_OE          <= write_op ? 8'hFF : 8'h00;
                        end else begin
                            ROM_AD_OUT <= (byte_idx == 2'd0) ? addr[15:8] : addr[7:0];
                        end
                    end else begin
                        ROM_AD_OUT <= addr_byte;
                    end
                end
                RSPC_PAR_DATA: begin
                    cnt <= cnt + CNT_W'(1);
                    if (data_end) begin
                        state <= RSPC_IDLE;
                        DONE  <= 1'b1;
                        if (!write_op) begin
                            PAR_RDATA <= ROM_AD_IN;
                        end
                        ROM_AD_OE <= 8'h00;
                    end
                end
                RSPC_SER_SHIFT: begin
                    // Clock high in phase 0, sampled as it falls
                    ROM_AD_OUT[`RSPC_SER_CLOCK_POS] <= phase;
                    if (byte_end) begin
                        shreg <= {shreg[SER_BITS-2:0], read_bit};
                        ROM_AD_OUT[`RSPC_SER_WRITE_POS] <= shreg[SER_BITS-2];
                        cnt <= cnt + CNT_W'(1);
                        if (ser_end) begin
                            state             <= RSPC_IDLE;
                            DONE              <= 1'b1;
                            SER_RX            <= {shreg[SER_BITS-2:0], read_bit};
                            SERIAL_ROM_SELECT <= 1'b0;
                            ROM_AD_OE         <= 8'h00;
                            ROM_AD_OUT        <= 8'h00;
                        end
                    end
                end
                default: begin
                    state <= RSPC_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Strap driven controls
    // ****************************************************************
    always_ff @(posedge SYS_CLK) begin
        ARB_ENABLE          <= straps.arb_enable;
        OWN_REQ_ON_GNT0     <= ~straps.arb_enable;
        SEC_WIDE_REQUEST_N  <= 1'b0;
        SEC_WIDE_REQUEST_OE <= SEC_RESET && !straps.central_tristate;
        SEC_BUS_PARK_LOW    <= SEC_RESET && !straps.central_tristate;
        SEC_CLK_ENABLE      <= straps.sec_clk_enable;
        ASYNC_MODE          <= straps.async_mode;
        PRIMARY_LOCKOUT     <= lockout;
        CONFIG_RETRY        <= lockout && !SYS_RST;
    end

endmodule // rspc_top

// ---- testbench/rspc_top_props.sv ----
// Concurrent checks on the ports of the ROM shared port sequencer
`timescale 1ns/1ps
module rspc_top_props #(
    parameter int DATA_CYCLES = 4,
    parameter int SER_BITS    = 16
) (
    input wire logic       SYS_CLK,
    input wire logic       SYS_RST,
    input wire logic [7:0] ROM_AD_OE,
    input wire logic       ROM_LATCH_ENABLE_N,
    input wire logic       ROM_LATCH_CLOCK,
    input wire logic       SERIAL_ROM_SELECT,
    input wire logic       BUSY,
    input wire logic       DONE,
    input wire logic       ARB_ENABLE,
    input wire logic       OWN_REQ_ON_GNT0,
    input wire logic       SEC_CLK_ENABLE,
    input wire logic       ASYNC_MODE,
    input wire logic       PRIMARY_LOCKOUT
);
    localparam int PAR_LAT = DATA_CYCLES + 6;
    localparam int SER_LAT = 2 * SER_BITS;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // ************************************************************
    // Properties
    // ************************************************************
    property p_undriven;
        $fell(SYS_RST) |-> $past(ROM_AD_OE) == 8'h00 && !$past(SERIAL_ROM_SELECT);
    endproperty
    a_undriven: assert property (p_undriven) else $error("pins driven in reset");
    property p_strap_hold;
        !$past(SYS_RST) |-> $stable(ARB_ENABLE) && $stable(ASYNC_MODE) && $stable(SEC_CLK_ENABLE);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");
    property p_arb_pair;
        ARB_ENABLE != OWN_REQ_ON_GNT0;
    endproperty
    a_arb_pair: assert property (p_arb_pair) else $error("arbiter pair wrong");
    property p_lclk;
        !$past(SYS_RST) |-> ROM_LATCH_CLOCK != $past(ROM_LATCH_CLOCK);
    endproperty
    a_lclk: assert property (p_lclk) else $error("latch clock not halved");
    property p_par_le;
        $rose(BUSY) && ROM_AD_OE == 8'hff |-> !ROM_LATCH_ENABLE_N [*6] ##1 ROM_LATCH_ENABLE_N;
    endproperty
    a_par_le: assert property (p_par_le) else $error("latch enable span");
    property p_par_done;
        $rose(BUSY) && ROM_AD_OE == 8'hff |-> ##PAR_LAT DONE;
    endproperty
    a_par_done: assert property (p_par_done) else $error("parallel end late");
    property p_ser_lines;
        SERIAL_ROM_SELECT |-> (ROM_AD_OE & 8'hfa) == 8'h00;
    endproperty
    a_ser_lines: assert property (p_ser_lines) else $error("serial pin use");
    property p_ser_done;
        $rose(SERIAL_ROM_SELECT) && ROM_AD_OE == 8'h05 |-> ##SER_LAT (DONE && !SERIAL_ROM_SELECT);
    endproperty
    a_ser_done: assert property (p_ser_done) else $error("serial select span");
    property p_lockout;
        !PRIMARY_LOCKOUT |=> !PRIMARY_LOCKOUT;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout set again");
    c_par: cover property ($rose(BUSY) && ROM_AD_OE == 8'hff);
    c_ser: cover property ($rose(SERIAL_ROM_SELECT) && ROM_AD_OE == 8'h05);
    c_clear: cover property ($fell(PRIMARY_LOCKOUT));
endmodule // rspc_top_props

bind rspc_top rspc_top_props #(.DATA_CYCLES(DATA_CYCLES), .SER_BITS(SER_BITS)) i_rspc_top_props (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ROM_AD_OE(ROM_AD_OE),
    .ROM_LATCH_ENABLE_N(ROM_LATCH_ENABLE_N), .ROM_LATCH_CLOCK(ROM_LATCH_CLOCK),
    .SERIAL_ROM_SELECT(SERIAL_ROM_SELECT), .BUSY(BUSY), .DONE(DONE),
    .ARB_ENABLE(ARB_ENABLE), .OWN_REQ_ON_GNT0(OWN_REQ_ON_GNT0),
    .SEC_CLK_ENABLE(SEC_CLK_ENABLE), .ASYNC_MODE(ASYNC_MODE), .PRIMARY_LOCKOUT(PRIMARY_LOCKOUT)
);

// ---- testbench/rspc_rom_model.sv ----
// Far side of the shared ROM pins: strap resistors, serial and parallel ROM
`timescale 1ns/1ps
module rspc_rom_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  oe,
    input  wire logic [7:0]  dout,
    input  wire logic        sel,
    input  wire logic [7:0]  pull,
    input  wire logic [15:0] word,
    input  wire logic [7:0]  rdata,
    output logic      [7:0]  pins,
    output logic      [15:0] got
);
    logic [15:0] sh;
    logic        ck_q;
    logic [7:0]  far;
    // Resistors set the pins in reset; pin 2 follows pull[2] for the bias
    assign far = sel ? {pull[7:2], sh[15], pull[0]} : (rst ? pull : rdata);
    assign pins = (oe & dout) | (~oe & far);
    always_ff @(posedge clk) begin
        ck_q <= pins[0];
        if (!sel) sh <= word;
        else if (ck_q && !pins[0]) sh <= {sh[14:0], ~sh[0]};
        if (sel && !ck_q && pins[0]) got <= {got[14:0], pins[2]};
    end
endmodule // rspc_rom_model

// ---- testbench/rom_port_strap_config_tb.sv ----
// Self-checking bench of the ROM shared port and strap capture block
`timescale 1ns/1ps
module rom_port_strap_config_tb;
    localparam int DC = 4;
    localparam int SB = 16;
    logic        clk;
    logic        rst = 1'b1;
    logic        par_req = 1'b0;
    logic        par_write = 1'b0;
    logic        ser_req = 1'b0;
    logic        sec_reset = 1'b0;
    logic        lk_clr = 1'b0;
    logic [23:0] par_addr = 24'h00_0000;
    logic [7:0]  par_wdata = 8'h00;
    logic [7:0]  pull = 8'hff;
    logic [7:0]  rdata = 8'h5a;
    logic [15:0] word = 16'hb5c3;
    logic [15:0] ser_tx = 16'h0000;
    logic [7:0]  pins, ad_out, ad_oe, par_rdata;
    logic [15:0] ser_rx, got;
    logic        le_n, lclk, sel, busy, done, pre_en, pre_done, bias, arb, own;
    logic        wreq_n, wreq_oe, park, sclk_en, async_m, lockout, retry;
    int          n_mismatch = 0;
    int          comparisons = 0;

    rspc_top #(.DATA_CYCLES(DC), .SER_BITS(SB)) i_rspc_top (
        .SYS_CLK(clk), .SYS_RST(rst), .ROM_AD_IN(pins), .ROM_AD_OUT(ad_out),
        .ROM_AD_OE(ad_oe), .ROM_LATCH_ENABLE_N(le_n), .ROM_LATCH_CLOCK(lclk),
        .SERIAL_ROM_SELECT(sel), .PAR_REQ(par_req), .PAR_WRITE(par_write),
        .PAR_ADDR(par_addr), .PAR_WDATA(par_wdata), .PAR_RDATA(par_rdata),
        .SER_REQ(ser_req), .SER_TX(ser_tx), .SER_RX(ser_rx), .BUSY(busy), .DONE(done),
        .PRELOAD_ENABLE(pre_en), .PRELOAD_DONE(pre_done), .SER_BIAS_LEVEL(bias),
        .SEC_RESET(sec_reset), .LOCKOUT_CLEAR(lk_clr), .ARB_ENABLE(arb),
        .OWN_REQ_ON_GNT0(own), .SEC_WIDE_REQUEST_N(wreq_n), .SEC_WIDE_REQUEST_OE(wreq_oe),
        .SEC_BUS_PARK_LOW(park), .SEC_CLK_ENABLE(sclk_en), .ASYNC_MODE(async_m),
        .PRIMARY_LOCKOUT(lockout), .CONFIG_RETRY(retry)
    );
    rspc_rom_model i_rspc_rom_model (
        .clk(clk), .rst(rst), .oe(ad_oe), .dout(ad_out), .sel(sel), .pull(pull),
        .word(word), .rdata(rdata), .pins(pins), .got(got)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 60 && busy !== 1'b0; i++) cyc(1);
        chk(busy, 0, "idle");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic do_reset(input logic [7:0] p, input logic [15:0] w);
        @(posedge clk);
        rst <= 1'b1;
        pull <= p;
        word <= w;
        cyc(16);
        chk({ad_oe, sel}, 0, "pins in reset");
        @(posedge clk);
        rst <= 1'b0;
        cyc(3);
        chk({arb, own, sclk_en, async_m, lockout}, {p[7], ~p[7], p[5:3]}, "straps");
        wait_idle();
        chk({pre_done, pre_en, bias, retry}, {1'b1, w[15:14] == 2'b10, p[2], p[3]}, "pre");
        $display("reset test %h ended", p);
    endtask
    task automatic sec_test(input logic p6);
        @(posedge clk);
        sec_reset <= 1'b1;
        cyc(3);
        chk({wreq_oe, park, wreq_n}, {~p6, ~p6, 1'b0}, "central park");
        @(posedge clk);
        sec_reset <= 1'b0;
        cyc(3);
        chk({wreq_oe, park}, 0, "park off");
        $display("secondary reset test ended");
    endtask
    task automatic par_access(input logic wr, input logic [23:0] a, input logic [7:0] d);
        wait_idle();
        @(posedge clk);
        par_req <= 1'b1;
        ser_req <= 1'b1;
        par_write <= wr;
        par_addr <= a;
        par_wdata <= d;
        for (int i = 0; i < 4 && busy !== 1'b1; i++) cyc(1);
        chk({ad_oe, ad_out, le_n, sel}, {8'hff, a[23:16], 2'b00}, "byte 2");
        @(posedge clk);
        par_req <= 1'b0;
        ser_req <= 1'b0;
        cyc(1);
        chk(ad_out, a[15:8], "byte 1");
        cyc(2);
        chk({ad_out, le_n}, {a[7:0], 1'b0}, "byte 0");
        cyc(2);
        chk({le_n, ad_oe, ad_out & {8{wr}}}, {1'b1, {8{wr}}, d & {8{wr}}}, "data");
        cyc(DC);
        chk({done, par_rdata & {8{~wr}}}, {1'b1, rdata & {8{~wr}}}, "done");
        $display("parallel test %h ended", a);
    endtask
    task automatic ser_access(input logic [15:0] tx);
        wait_idle();
        @(posedge clk);
        ser_req <= 1'b1;
        ser_tx <= tx;
        for (int i = 0; i < 4 && busy !== 1'b1; i++) cyc(1);
        chk({sel, ad_oe}, {1'b1, 8'h05}, "serial start");
        @(posedge clk);
        ser_req <= 1'b0;
        cyc(2 * SB - 1);
        chk({done, sel, ser_rx, got}, {2'b10, word, tx}, "serial end");
        $display("serial test ended");
    endtask
    task automatic lockout_test();
        @(posedge clk);
        lk_clr <= 1'b1;
        @(posedge clk);
        lk_clr <= 1'b0;
        cyc(3);
        chk({lockout, retry}, 0, "lockout cleared");
        $display("lockout test ended");
    endtask

    initial begin
        do_reset(8'hac, 16'hb5c3);
        sec_test(1'b0);
        par_access(1'b1, 24'ha5_c396, 8'h3c);
        par_access(1'b0, 24'h01_fe80, 8'h00);
        ser_access(16'h9b2d);
        lockout_test();
        do_reset(8'h50, 16'h4a5f);
        sec_test(1'b1);
        par_access(1'b0, 24'h7e_0001, 8'h00);
        close_out();
    end
    initial begin
        #50000;
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end
endmodule // rom_port_strap_config_tb
